// ---- hdl/osc_ctrl_pkg.sv ----
// constants for the primary oscillator start-up and auxiliary clock block
package osc_ctrl_pkg;
   // register map (word aligned, byte addresses)
   localparam logic [3:0]  AUX_CTRL_ADDR     = 4'h0;
   localparam logic [3:0]  OSC_STATUS_ADDR   = 4'h4;
   localparam logic [3:0]  RESTART_ADDR      = 4'h8;
   localparam logic [15:0] AUX_CTRL_RESET    = 16'h0000;
   localparam logic [15:0] AUX_CTRL_WMASK    = 16'h3F80;
   localparam logic [31:0] UNMAPPED_READ     = 32'h00000000;
   // aux_clock_control field positions
   localparam int AUX_DIV_SRC_BIT  = 13;
   localparam int AUX_MODE_HI      = 12;
   localparam int AUX_MODE_LO      = 11;
   localparam int AUX_DIV_HI       = 10;
   localparam int AUX_DIV_LO       = 8;
   localparam int AUX_REF_SRC_BIT  = 7;
   // status register field positions
   localparam int ST_READY_BIT     = 0;
   localparam int ST_OST_DONE_BIT  = 1;
   localparam int ST_SRC_LO        = 4;
   localparam int ST_SRC_HI        = 6;
   localparam int ST_AUX_READY_BIT = 8;
   // configuration words
   localparam int SRC_CFG_HI       = 2;
   localparam int PRI_MODE_HI      = 1;
   localparam int PIN_FUNC_BIT     = 2;
   localparam logic [2:0] SRC_PRI_NO_PLL  = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL     = 3'h3;
   localparam logic [2:0] SRC_FRC         = 3'h0;
   typedef enum logic [1:0] {
      PRI_EXT_CLOCK = 2'h0,
      PRI_CRYSTAL   = 2'h1,
      PRI_HIGH_GAIN = 2'h2,
      PRI_DISABLED  = 2'h3
   } pri_mode_type;
   typedef enum logic [1:0] {
      AUX_OFF       = 2'h0,
      AUX_HIGH_GAIN = 2'h1,
      AUX_CRYSTAL   = 2'h2,
      AUX_EXT_CLOCK = 2'h3
   } aux_mode_type;
   // start-up counter
   localparam int          OST_WIDTH  = 10;
   localparam logic [9:0]  OST_LAST   = 10'h3FF;
   localparam logic [7:0]  DIV_ONE    = 8'h00;
   // pll lock interval in microseconds, converted to core_clk cycles
   localparam int LOCK_TIME_US  = 20;
   localparam int CORE_CLK_MHZ  = 50;
   localparam int LOCK_CYCLES   = LOCK_TIME_US * CORE_CLK_MHZ;
   localparam int LOCK_WIDTH    = 11;
endpackage : osc_ctrl_pkg

// ---- hdl/ost_if.sv ----
// start-up counter control and status between top and counter
`timescale 1ns/1ns
`default_nettype none
interface ost_if;
   logic enable;
   logic restart;
   logic oscEdge;
   logic done;
   modport ctrl (output enable, output restart, output oscEdge,
                 input done);
   modport counter (input enable, input restart, input oscEdge,
                    output done);
endinterface : ost_if
`default_nettype wire

// ---- hdl/ost_counter.sv ----
// 10-bit oscillator start-up counter
`timescale 1ns/1ns
`default_nettype none
module ost_counter (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic arst_n,
   // control
   ost_if.counter    ost
);
   logic [osc_ctrl_pkg::OST_WIDTH-1:0] count_reg;
   logic [osc_ctrl_pkg::OST_WIDTH-1:0] count_next;
   logic                               done_reg;
   logic                               done_next;

   always_comb begin
      count_next = count_reg;
      done_next  = done_reg;
      if (!ost.enable || ost.restart) begin
         count_next = '0; // RULE19
         done_next  = 1'b0; // RULE11
      end else if (ost.oscEdge && !done_reg) begin
         // only qualified pin edges advance the count
         if (count_reg == osc_ctrl_pkg::OST_LAST) begin
            done_next = 1'b1; // RULE9
         end else begin
            count_next = count_reg + 1'b1; // RULE10
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= '0;
         done_reg  <= 1'b0;
      end else begin
         count_reg <= count_next;
         done_reg  <= done_next;
      end
   end

   assign ost.done = done_reg;
endmodule : ost_counter
`default_nettype wire

// ---- hdl/osc_startup_ctrl.sv ----
// primary oscillator start-up, pin routing and auxiliary clock control
// How it works
// RULE1: bit 13 picks aux divider source
// RULE2: bits 12-11 aux oscillator mode, reset off
// RULE3: bits 10-8 aux divider, 000 means 256
// RULE4: bit 7 picks aux reference source
// RULE5: unimplemented bits read zero, ignore writes
// RULE6: source 011 runs primary through pll
// RULE7: source 010 runs primary without pll
// RULE8: external clock bypasses amplifier, input pin
// RULE9: count 1024 oscillator cycles before release
// RULE10: count only valid-level oscillator edges
// RULE11: recount on por, brown-out, wake
// RULE12: ready after onset, count, then lock
// RULE13: pin function bit: io or instruction clock
// RULE14: mode 11 disables oscillator, input is io
// RULE15: crystal modes own both pins
// RULE16: config fields latched at power-on
// RULE17: current source reports 010 or 011
// RULE18: pll lock waits for count completion
// RULE19: counter clears when disabled or restarted
// RULE20: release synchronised, glitch-free clock gate
`timescale 1ns/1ns
`default_nettype none
module osc_startup_ctrl (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // nonvolatile configuration words
   input  wire logic [2:0]  sourceConfigWord,
   input  wire logic [2:0]  oscConfigWord,
   // restart events
   input  wire logic        brownOutReset,
   input  wire logic        sleepWake,
   // oscillator pins
   input  wire logic        crystalInputPinIn,
   input  wire logic        auxOscPinIn,
   output logic             amplifierEnable,
   output logic             crystalOutputPinOut,
   output logic             crystalOutputPinOe,
   output logic             crystalInputPinOe,
   // pin io and instruction clock
   input  wire logic        instrClock,
   input  wire logic        gpioOutData,
   input  wire logic        gpioOutEnable,
   // pll and clock release
   input  wire logic        pllLocked,
   output logic             pllEnable,
   output logic             clockReady,
   output logic             clockGateEnable,
   output logic [2:0]       currentSourceField,
   // auxiliary clock selects
   output logic             auxDividerSourceSelect,
   output logic [1:0]       auxOscillatorMode,
   output logic [7:0]       auxDivideRatioMinusOne,
   output logic             auxReferenceSourceSelect,
   output logic             auxOscEnable,
   output logic             auxAmplifierEnable
);
   ////////////////////////////////////////////////////////////////////
   // configuration capture after reset release
   logic       cfgValid_reg;
   logic       cfgValid_next;
   logic [2:0] srcCfg_reg;
   logic [2:0] srcCfg_next;
   logic [2:0] oscCfg_reg;
   logic [2:0] oscCfg_next;

   always_comb begin
      cfgValid_next = 1'b1;
      srcCfg_next   = srcCfg_reg;
      oscCfg_next   = oscCfg_reg;
      if (!cfgValid_reg) begin
         srcCfg_next = sourceConfigWord; // RULE16
         oscCfg_next = oscConfigWord; // RULE16
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfgValid_reg <= 1'b0;
         srcCfg_reg   <= osc_ctrl_pkg::SRC_FRC;
         oscCfg_reg   <= {1'b0, osc_ctrl_pkg::PRI_DISABLED};
      end else begin
         cfgValid_reg <= cfgValid_next;
         srcCfg_reg   <= srcCfg_next;
         oscCfg_reg   <= oscCfg_next;
      end
   end

   osc_ctrl_pkg::pri_mode_type priMode;
   logic usePrimary;
   logic usePll;
   logic pinFunc;
   assign priMode    = osc_ctrl_pkg::pri_mode_type'(
                          oscCfg_reg[osc_ctrl_pkg::PRI_MODE_HI:0]);
   assign pinFunc    = oscCfg_reg[osc_ctrl_pkg::PIN_FUNC_BIT];
   assign usePll     = cfgValid_reg &&
                       (srcCfg_reg == osc_ctrl_pkg::SRC_PRI_PLL); // RULE6
   assign usePrimary = cfgValid_reg &&
                       (usePll ||
                        srcCfg_reg == osc_ctrl_pkg::SRC_PRI_NO_PLL) &&
                       (priMode != osc_ctrl_pkg::PRI_DISABLED); // RULE7

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge qualification
   logic [1:0] priSync_reg;
   logic [1:0] auxSync_reg;
   logic       priLast_reg;
   logic       auxLast_reg;
   logic       wakeSync1_reg;
   logic       wakeSync2_reg;
   logic       borSync1_reg;
   logic       borSync2_reg;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         priSync_reg   <= 2'h0;
         auxSync_reg   <= 2'h0;
         priLast_reg   <= 1'b0;
         auxLast_reg   <= 1'b0;
         wakeSync1_reg <= 1'b0;
         wakeSync2_reg <= 1'b0;
         borSync1_reg  <= 1'b0;
         borSync2_reg  <= 1'b0;
      end else begin
         priSync_reg   <= {priSync_reg[0], crystalInputPinIn};
         auxSync_reg   <= {auxSync_reg[0], auxOscPinIn};
         priLast_reg   <= priSync_reg[1];
         auxLast_reg   <= auxSync_reg[1];
         wakeSync1_reg <= sleepWake;
         wakeSync2_reg <= wakeSync1_reg;
         borSync1_reg  <= brownOutReset;
         borSync2_reg  <= borSync1_reg;
      end
   end

   // a clean rising edge after synchronisation means the pin swings
   // through valid logic levels; sub-threshold ringing never toggles it
   logic priEdge;
   logic auxEdge;
   logic restartEvent;
   assign priEdge      = priSync_reg[1] && !priLast_reg; // RULE10
   assign auxEdge      = auxSync_reg[1] && !auxLast_reg;
   assign restartEvent = wakeSync2_reg || borSync2_reg; // RULE11

   ////////////////////////////////////////////////////////////////////
   // register file
   logic [15:0] auxCtrl_reg;
   logic [15:0] auxCtrl_next;
   logic        swRestart_reg;
   logic        swRestart_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [31:0] statusWord;
   logic        priDone;
   logic        auxDone;
   logic        pllDone_reg;

   always_comb begin
      statusWord = 32'h00000000;
      statusWord[osc_ctrl_pkg::ST_READY_BIT]    = clockReady;
      statusWord[osc_ctrl_pkg::ST_OST_DONE_BIT] = priDone;
      statusWord[osc_ctrl_pkg::ST_SRC_HI:osc_ctrl_pkg::ST_SRC_LO] =
         currentSourceField;
      statusWord[osc_ctrl_pkg::ST_AUX_READY_BIT] = auxDone;
   end

   always_comb begin
      auxCtrl_next   = auxCtrl_reg;
      swRestart_next = 1'b0;
      rdata_next     = rdata_reg;
      if (avs_write && avs_address == osc_ctrl_pkg::AUX_CTRL_ADDR) begin
         if (avs_byteenable[0]) begin
            auxCtrl_next[7:0] = avs_writedata[7:0] &
                                osc_ctrl_pkg::AUX_CTRL_WMASK[7:0]; // RULE5
         end
         if (avs_byteenable[1]) begin
            auxCtrl_next[15:8] = avs_writedata[15:8] &
                                 osc_ctrl_pkg::AUX_CTRL_WMASK[15:8]; // RULE5
         end
      end
      if (avs_write && avs_address == osc_ctrl_pkg::RESTART_ADDR &&
          avs_byteenable[0]) begin
         swRestart_next = avs_writedata[0];
      end
      if (avs_read) begin
         case (avs_address)
            osc_ctrl_pkg::AUX_CTRL_ADDR:
               rdata_next = {16'h0000, auxCtrl_reg}; // RULE5
            osc_ctrl_pkg::OSC_STATUS_ADDR:
               rdata_next = statusWord;
            default:
               rdata_next = osc_ctrl_pkg::UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         auxCtrl_reg   <= osc_ctrl_pkg::AUX_CTRL_RESET;
         swRestart_reg <= 1'b0;
         rdata_reg     <= 32'h00000000;
      end else begin
         auxCtrl_reg   <= auxCtrl_next;
         swRestart_reg <= swRestart_next;
         rdata_reg     <= rdata_next;
      end
   end

   // zero-wait writes: every write completes in its first cycle,
   // read data is registered one cycle later via readdatavalid-free
   // timing, so reads wait one cycle
   logic rdPending_reg;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdPending_reg <= 1'b0;
      end else begin
         rdPending_reg <= avs_read && !rdPending_reg;
      end
   end
   assign avs_waitrequest = avs_read && !rdPending_reg;
   assign avs_readdata    = rdata_reg;

   ////////////////////////////////////////////////////////////////////
   // start-up counters
   ost_if priOst ();
   ost_if auxOst ();

   assign priOst.enable  = usePrimary;
   assign priOst.restart = restartEvent || swRestart_reg || !cfgValid_reg;
   assign priOst.oscEdge = priEdge;
   assign priDone        = priOst.done;

   assign auxOst.enable  = auxOscillatorMode != osc_ctrl_pkg::AUX_OFF;
   assign auxOst.restart = restartEvent || swRestart_reg;
   assign auxOst.oscEdge = auxEdge;
   assign auxDone        = auxOst.done;

   ost_counter priCounter (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ost      (priOst.counter)
   );

   ost_counter auxCounter (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ost      (auxOst.counter)
   );

   ////////////////////////////////////////////////////////////////////
   // pll lock interval, started only after the count completes
   logic [osc_ctrl_pkg::LOCK_WIDTH-1:0] lockCnt_reg;
   logic [osc_ctrl_pkg::LOCK_WIDTH-1:0] lockCnt_next;
   logic                                pllDone_next;
   logic                                ready_reg;
   logic                                ready_next;
   logic                                gate_reg;
   logic [1:0]                          pllSync_reg;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pllSync_reg <= 2'h0;
      end else begin
         pllSync_reg <= {pllSync_reg[0], pllLocked};
      end
   end

   always_comb begin
      lockCnt_next = lockCnt_reg;
      pllDone_next = pllDone_reg;
      if (!usePll || !priDone) begin
         lockCnt_next = '0; // RULE18
         pllDone_next = 1'b0;
      end else if (!pllDone_reg) begin
         if (lockCnt_reg == osc_ctrl_pkg::LOCK_WIDTH'(
                osc_ctrl_pkg::LOCK_CYCLES - 1) && pllSync_reg[1]) begin
            pllDone_next = 1'b1; // RULE12
         end else if (lockCnt_reg != osc_ctrl_pkg::LOCK_WIDTH'(
                osc_ctrl_pkg::LOCK_CYCLES - 1)) begin
            lockCnt_next = lockCnt_reg + 1'b1;
         end
      end
      ready_next = priDone && (!usePll || pllDone_reg); // RULE12
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lockCnt_reg <= '0;
         pllDone_reg <= 1'b0;
         ready_reg   <= 1'b0;
      end else begin
         lockCnt_reg <= lockCnt_next;
         pllDone_reg <= pllDone_next;
         ready_reg   <= ready_next;
      end
   end

   // gate enable changes on the falling edge so a latch-free and-gate
   // downstream never sees it move while the clock is high
   always_ff @(negedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         gate_reg <= 1'b0;
      end else begin
         gate_reg <= ready_reg; // RULE20
      end
   end

   assign clockReady      = ready_reg;
   assign clockGateEnable = gate_reg;
   assign pllEnable       = usePll;
   assign currentSourceField = !usePrimary ? osc_ctrl_pkg::SRC_FRC :
                               usePll ? osc_ctrl_pkg::SRC_PRI_PLL :
                               osc_ctrl_pkg::SRC_PRI_NO_PLL; // RULE17

   ////////////////////////////////////////////////////////////////////
   // pin routing
   always_comb begin
      amplifierEnable     = 1'b0;
      crystalInputPinOe   = 1'b0;
      crystalOutputPinOe  = 1'b0;
      crystalOutputPinOut = 1'b0;
      case (priMode)
         osc_ctrl_pkg::PRI_HIGH_GAIN,
         osc_ctrl_pkg::PRI_CRYSTAL: begin
            amplifierEnable = 1'b1; // RULE15
         end
         osc_ctrl_pkg::PRI_EXT_CLOCK: begin
            amplifierEnable = 1'b0; // RULE8
            crystalOutputPinOe  = pinFunc ? 1'b1 : gpioOutEnable; // RULE13
            crystalOutputPinOut = pinFunc ? instrClock : gpioOutData;
         end
         osc_ctrl_pkg::PRI_DISABLED: begin
            crystalInputPinOe   = 1'b0; // RULE14
            crystalOutputPinOe  = pinFunc ? 1'b1 : gpioOutEnable; // RULE13
            crystalOutputPinOut = pinFunc ? instrClock : gpioOutData;
         end
         default: begin
            amplifierEnable = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // auxiliary clock selects
   assign auxDividerSourceSelect   = auxCtrl_reg[osc_ctrl_pkg::AUX_DIV_SRC_BIT]; // RULE1
   assign auxOscillatorMode        =
      auxCtrl_reg[osc_ctrl_pkg::AUX_MODE_HI:osc_ctrl_pkg::AUX_MODE_LO]; // RULE2
   assign auxReferenceSourceSelect = auxCtrl_reg[osc_ctrl_pkg::AUX_REF_SRC_BIT]; // RULE4
   assign auxOscEnable             = auxDone;
   assign auxAmplifierEnable       =
      auxOscillatorMode == osc_ctrl_pkg::AUX_CRYSTAL ||
      auxOscillatorMode == osc_ctrl_pkg::AUX_HIGH_GAIN;

   logic [2:0] divCode;
   assign divCode = auxCtrl_reg[osc_ctrl_pkg::AUX_DIV_HI:osc_ctrl_pkg::AUX_DIV_LO];
   always_comb begin
      // ratio minus one: 111 -> 1, 001 -> 64, 000 -> 256
      if (divCode == 3'h0) begin
         auxDivideRatioMinusOne = 8'hFF; // RULE3
      end else begin
         auxDivideRatioMinusOne = 8'((9'h001 << (3'h7 - divCode)) - 9'h001); // RULE3
      end
   end
endmodule : osc_startup_ctrl
`default_nettype wire

// ---- tb/osc_source_model.sv ----
// behavioural crystal or external clock at an oscillator pin
`timescale 1ns/1ns
`default_nettype none
module osc_source_model #(
   parameter int HALF_NS = 70
) (
   // control
   input  wire logic run,
   // pin
   output var logic  pin
);
   initial pin = 1'h0;
   // full-swing edges only; a stopped source rests low
   always begin
      #HALF_NS;
      pin = run ? ~pin : 1'h0;
   end
endmodule : osc_source_model
`default_nettype wire

// ---- tb/osc_startup_ctrl_props.sv ----
// assertions on the oscillator start-up and aux clock ports
`timescale 1ns/1ns
`default_nettype none
module osc_startup_ctrl_props (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        arst_n,
   // register bus
   input wire logic [3:0]  avs_address,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic [31:0] avs_writedata,
   // configuration and restart
   input wire logic [2:0]  sourceConfigWord,
   input wire logic [2:0]  oscConfigWord,
   input wire logic        brownOutReset,
   input wire logic        sleepWake,
   // pins
   input wire logic        crystalInputPinIn,
   input wire logic        amplifierEnable,
   input wire logic        crystalOutputPinOut,
   input wire logic        crystalOutputPinOe,
   input wire logic        instrClock,
   input wire logic        gpioOutData,
   input wire logic        gpioOutEnable,
   // release
   input wire logic        pllLocked,
   input wire logic        pllEnable,
   input wire logic        clockReady,
   input wire logic        clockGateEnable,
   input wire logic [2:0]  currentSourceField,
   input wire logic [1:0]  auxOscillatorMode
);
   logic        cfgValid_reg, cfgValid_next, pinPrev_reg, pinPrev_next;
   logic [15:0] edgeCnt_reg, edgeCnt_next;
   logic [1:0]  mode, wrMode;
   logic        clr, ioMode;
   assign mode   = oscConfigWord[1:0];
   assign wrMode = avs_writedata[12:11];
   assign ioMode = (mode == 2'h0) || (mode == 2'h3);
   // raw edges; synchroniser lag costs slack
   assign clr = brownOutReset || sleepWake || (avs_write
                && avs_address == osc_ctrl_pkg::RESTART_ADDR
                && avs_writedata[0]);
   always_comb begin
      cfgValid_next = 1'h1;
      pinPrev_next  = crystalInputPinIn;
      edgeCnt_next  = edgeCnt_reg;
      if (clr)
         edgeCnt_next = 16'h0000;
      else if (crystalInputPinIn && !pinPrev_reg && edgeCnt_reg != 16'hFFFF)
         edgeCnt_next = edgeCnt_reg + 16'h0001;
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfgValid_reg <= 1'h0;
         pinPrev_reg  <= 1'h0;
         edgeCnt_reg  <= 16'h0000;
      end else begin
         cfgValid_reg <= cfgValid_next;
         pinPrev_reg  <= pinPrev_next;
         edgeCnt_reg  <= edgeCnt_next;
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   chk_pll_source: assert property (cfgValid_reg && mode != 2'h3
      && sourceConfigWord == 3'h3 |-> pllEnable && currentSourceField == 3'h3)
      else $error("pll source");
   chk_direct_source: assert property (cfgValid_reg && mode != 2'h3
      && sourceConfigWord == 3'h2 |-> !pllEnable && currentSourceField == 3'h2)
      else $error("direct source");
   chk_amp_modes: assert property (cfgValid_reg |->
      amplifierEnable == (mode == 2'h1 || mode == 2'h2))
      else $error("amplifier");
   chk_out_pin_io: assert property (cfgValid_reg && ioMode
      && !oscConfigWord[2] |-> crystalOutputPinOe == gpioOutEnable
      && crystalOutputPinOut == gpioOutData)
      else $error("pin io");
   chk_out_pin_clk: assert property (cfgValid_reg && ioMode
      && oscConfigWord[2] |-> crystalOutputPinOe && crystalOutputPinOut == instrClock)
      else $error("pin clock");
   chk_startup_count: assert property ($rose(clockReady) && !pllEnable
      |-> edgeCnt_reg inside {[16'h03FF:16'h0402]})
      else $error("start-up count");
   chk_lock_after_count: assert property ($rose(clockReady) && pllEnable
      |-> edgeCnt_reg >= 16'h047E && $past(pllLocked))
      else $error("pll lock order");
   chk_restart_drops: assert property ($rose(brownOutReset) ||
      $rose(sleepWake) |-> ##[1:6] !clockReady)
      else $error("restart");
   chk_gate_follows: assert property (clockGateEnable == clockReady)
      else $error("clock gate");
   chk_aux_mode_write: assert property (avs_write && !avs_waitrequest
      && avs_address == osc_ctrl_pkg::AUX_CTRL_ADDR
      |=> auxOscillatorMode == $past(wrMode))
      else $error("aux mode");
   cover property ($rose(clockReady) && pllEnable);
   cover property ($rose(clockReady) && !pllEnable);
   cover property ($rose(brownOutReset));
endmodule : osc_startup_ctrl_props
bind osc_startup_ctrl osc_startup_ctrl_props u_props (.*);
`default_nettype wire

// ---- tb/primary_osc_startup_and_aux_clock_bench.sv ----
// self-checking bench for the oscillator start-up and aux clock block
`timescale 1ns/1ns
`default_nettype none
module primary_osc_startup_and_aux_clock_bench;
   logic        core_clk, arst_n, rd, wr, wait_, bor, wake, pinIn, auxPin;
   logic        run, amp, outPin, outOe, inOe, instr, gpioD, gpioE, locked;
   logic        pllEn, ready, gate, divSrc, refSrc, auxEn, auxAmp;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, d;
   logic [2:0]  src, osc, curSrc;
   logic [1:0]  auxMode;
   logic [7:0]  auxDiv;
   logic [7:0]  divTab [8] = '{8'hFF, 8'h3F, 8'h1F, 8'h0F, 8'h07, 8'h03,
                               8'h01, 8'h00};
   logic [31:0] expQ [$];
   int          mismatches, samples_checked, cycles;
   osc_startup_ctrl u_dut (.core_clk(core_clk), .arst_n(arst_n),
      .avs_address(addr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
      .avs_waitrequest(wait_), .sourceConfigWord(src), .oscConfigWord(osc),
      .brownOutReset(bor), .sleepWake(wake), .crystalInputPinIn(pinIn),
      .auxOscPinIn(auxPin), .amplifierEnable(amp), .crystalOutputPinOut(outPin),
      .crystalOutputPinOe(outOe), .crystalInputPinOe(inOe), .instrClock(instr),
      .gpioOutData(gpioD), .gpioOutEnable(gpioE), .pllLocked(locked),
      .pllEnable(pllEn), .clockReady(ready), .clockGateEnable(gate),
      .currentSourceField(curSrc), .auxDividerSourceSelect(divSrc),
      .auxOscillatorMode(auxMode), .auxDivideRatioMinusOne(auxDiv),
      .auxReferenceSourceSelect(refSrc), .auxOscEnable(auxEn),
      .auxAmplifierEnable(auxAmp));
   osc_source_model #(.HALF_NS(70)) u_xtal (.run(run), .pin(pinIn));
   osc_source_model #(.HALF_NS(90)) u_aux (.run(1'h1), .pin(auxPin));
   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic end_of_test;
      if (mismatches == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   // one bus transfer; reads queue their expectation
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] dw, input logic [31:0] e);
      @(posedge core_clk);
      {addr, wdata, wr, rd} <= {a, dw, w, !w};
      if (!w)
         expQ.push_back(e);
      @(negedge core_clk);
      while (wait_ !== 1'h0)
         @(negedge core_clk);
      @(posedge core_clk);
      {wr, rd} <= 2'h0;
      @(negedge core_clk);
   endtask : bus
   task automatic boot(input logic [2:0] s, input logic [2:0] o,
                       input logic lk);
      @(posedge core_clk);
      {arst_n, src, osc, locked} <= {1'h0, s, o, lk};
      run    <= (o[1:0] != 2'h3);
      repeat (6) @(posedge core_clk);
      arst_n <= 1'h1;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
   endtask : boot
   task automatic waitFor(input int lim, input logic aux);
      int n;
      n = 0;
      while ((aux ? auxEn : ready) !== 1'h1 && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      check(aux ? "auxOscEnable" : "clockReady", 1'h1, aux ? auxEn : ready);
   endtask : waitFor
   task automatic pulse(input logic b);
      @(posedge core_clk);
      if (b) bor <= 1'h1;
      else wake <= 1'h1;
      repeat (4) @(posedge core_clk);
      bor  <= 1'h0;
      wake <= 1'h0;
      repeat (3) @(negedge core_clk);
      check("clockReady", 1'h0, ready);
   endtask : pulse
   always @(posedge core_clk) begin
      instr <= ~instr;
      gpioD <= 1'($urandom);
      gpioE <= 1'($urandom);
      if (rd && !wait_ && expQ.size() > 0)
         check("readdata", expQ.pop_front(), rdata);
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(69924));
      {mismatches, samples_checked, cycles} = '0;
      {arst_n, rd, wr, bor, wake, run, instr, gpioD, gpioE, locked} = '0;
      {addr, wdata, src, osc} = '0;
      boot(3'h2, 3'h0, 1'h0);
      bus(1'h0, osc_ctrl_pkg::AUX_CTRL_ADDR, 32'h0, 32'h0);
      bus(1'h0, 4'hC, 32'h0, 32'h0);
      for (int c = 0; c < 8; c++) begin
         d = $urandom;
         d[13:7] = {c[2], c[1:0], c[2:0], c[0]};
         bus(1'h1, osc_ctrl_pkg::AUX_CTRL_ADDR, d, 32'h0);
         check("auxMode", d[12:11], auxMode);
         check("auxDiv", divTab[c], auxDiv);
         check("divSrc", d[13], divSrc);
         check("refSrc", d[7], refSrc);
         check("auxAmp", c[1] ^ c[0], auxAmp);
         bus(1'h0, osc_ctrl_pkg::AUX_CTRL_ADDR, 32'h0, d & 32'h3F80);
      end
      for (int m = 3; m >= 0; m--) begin
         boot(3'h2, {m[0], m[1:0]}, 1'h0);
         check("curSrc", (m == 3) ? 3'h0 : 3'h2, curSrc);
         check("amp", m == 1 || m == 2, amp);
         check("inOe", 1'h0, inOe);
         if (m != 3)
            waitFor(9000, 1'h0);
         bus(1'h0, 4'h4, 32'h0, (m == 3) ? 32'h0 : 32'h23);
      end
      bus(1'h1, osc_ctrl_pkg::RESTART_ADDR, 32'h1, 32'h0);
      repeat (3) @(negedge core_clk);
      check("clockReady", 1'h0, ready);
      waitFor(9000, 1'h0);
      pulse(1'h0);
      waitFor(9000, 1'h0);
      boot(3'h3, 3'h1, 1'h0);
      check("pllEn", 1'h1, pllEn);
      repeat (8500) @(negedge core_clk);
      check("clockReady", 1'h0, ready);
      @(posedge core_clk);
      locked <= 1'h1;
      waitFor(40, 1'h0);
      pulse(1'h1);
      waitFor(9000, 1'h0);
      bus(1'h1, osc_ctrl_pkg::AUX_CTRL_ADDR, 32'h1000, 32'h0);
      waitFor(11000, 1'h1);
      bus(1'h0, 4'h4, 32'h0, 32'h133);
      end_of_test();
   end
endmodule : primary_osc_startup_and_aux_clock_bench
`default_nettype wire
